// [rtl/clock_manager_ctrl.v]
// Control registers, power sequencing and three programmable dividers of a clock manager.
// Assumes the fabric strobes, address, data, configuration-done and global reset are
// asynchronous to core_clk, and that ref_clk_en is a one-cycle enable from core logic.
`timescale 1ns/10ps
`default_nettype none
`include "clock_manager_map.vh"

module clock_manager_ctrl #(
    parameter WAKEUP_CYC   = (`WAKEUP_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS,
    parameter ACQUIRE_CYC  = (`ACQUIRE_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS,
    parameter SHUTDOWN_CYC = (`SHUTDOWN_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS
) (
    input  wire       core_clk,
    input  wire       nrst,
    input  wire [2:0] reg_addr,
    input  wire [7:0] wr_data,
    input  wire       read_strobe,
    input  wire       write_strobe,
    input  wire       config_done,
    input  wire       global_set_reset_n,
    input  wire       ref_clk_en,
    output reg  [7:0] rd_data,
    output reg  [7:0] rd_data_oe_n,
    output reg        analog_power_on,
    output reg        dll_func_rst,
    output reg        pll_func_rst,
    output reg        out_clk_unstable,
    output reg        lock,
    output reg        prescaler_en,
    output reg        feedback_en,
    output reg        delay_line_en,
    output reg  [3:0] prescaler_ratio,
    output reg  [3:0] feedback_ratio,
    output reg  [3:0] delay_line_ratio,
    output reg  [3:0] duty_first_16ths,
    output reg  [3:0] duty_second_16ths
);

    // ======================================================================
    // Input synchronisers
    // Address and data are sampled beside the strobe. The fabric holds them steady
    // before raising it, so the words are settled when the synchronised edge is seen.
    reg  [2:0] addr_s1_ff;
    reg  [2:0] addr_s2_ff;
    reg  [7:0] data_s1_ff;
    reg  [7:0] data_s2_ff;
    reg  [3:0] ctl_s1_ff;
    reg  [3:0] ctl_s2_ff;
    reg        we_prev_ff;

    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_s1_ff <= 3'h0;
            addr_s2_ff <= 3'h0;
            data_s1_ff <= 8'h00;
            data_s2_ff <= 8'h00;
            ctl_s1_ff  <= 4'h2;
            ctl_s2_ff  <= 4'h2;
            we_prev_ff <= 1'b0;
        end
        else
        begin
            addr_s1_ff <= reg_addr;
            addr_s2_ff <= addr_s1_ff;
            data_s1_ff <= wr_data;
            data_s2_ff <= data_s1_ff;
            ctl_s1_ff  <= {read_strobe, write_strobe, global_set_reset_n, config_done};
            ctl_s2_ff  <= ctl_s1_ff;
            we_prev_ff <= ctl_s2_ff[2];
        end
    end

    wire re_sync   = ctl_s2_ff[3];
    wire we_sync   = ctl_s2_ff[2];
    wire gsr_n     = ctl_s2_ff[1];
    wire done_sync = ctl_s2_ff[0];
    // Write is refused while a read is active; the two strobes must not overlap.
    wire wr_pulse  = we_sync & ~we_prev_ff & ~re_sync;

    // ======================================================================
    // Control registers
    reg  [7:0] prescaler_ctrl_ff;
    reg  [7:0] feedback_ctrl_ff;
    reg  [7:0] delay_ctrl_ff;
    reg  [7:0] duty_ctrl_ff;
    reg  [7:0] control_ff;

    // The global reset clears the divider settings only; the duty and control registers,
    // and so the immunity bit itself, survive it.
    wire gsr_hit = ~gsr_n & ~control_ff[`CTL_GSR_IMMUNE];

    // Function resets never touch these registers; only nrst and the global reset do.
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prescaler_ctrl_ff <= `DIV_RESET;
            feedback_ctrl_ff  <= `DIV_RESET;
            delay_ctrl_ff     <= `DIV_RESET;
            duty_ctrl_ff      <= `DUTY_RESET;
            control_ff        <= `CONTROL_RESET;
        end
        else if (gsr_hit)
        begin
            prescaler_ctrl_ff <= `DIV_RESET;
            feedback_ctrl_ff  <= `DIV_RESET;
            delay_ctrl_ff     <= `DIV_RESET;
        end
        else if (wr_pulse)
        begin
            case (addr_s2_ff)
                `REG_PRESCALER:  prescaler_ctrl_ff <= data_s2_ff & `DIV_WR_MASK;
                `REG_FEEDBACK:   feedback_ctrl_ff  <= data_s2_ff & `DIV_WR_MASK;
                `REG_DELAY_LINE: delay_ctrl_ff     <= data_s2_ff & `DIV_WR_MASK;
                `REG_DUTY:       duty_ctrl_ff      <= data_s2_ff;
                `REG_CONTROL:    control_ff        <= data_s2_ff & `CTL_WR_MASK;
                default:         control_ff        <= control_ff;
            endcase
        end
    end

    // ======================================================================
    // Read port
    function [7:0] read_mux;
        input [2:0] a;
        begin
            case (a)
                `REG_PRESCALER:  read_mux = prescaler_ctrl_ff;
                `REG_FEEDBACK:   read_mux = feedback_ctrl_ff;
                `REG_DELAY_LINE: read_mux = delay_ctrl_ff;
                `REG_DUTY:       read_mux = duty_ctrl_ff;
                `REG_CONTROL:    read_mux = control_ff;
                default:         read_mux = 8'h00;
            endcase
        end
    endfunction

    // Divide-ratio decode shared by the three dividers; a held reset forces bypass.
    function [3:0] ratio_of;
        input [7:0] r;
        begin
            if (r[`DIV_RST_BIT] || r[`DIV_VAL_MSB:0] == 4'h0)
                ratio_of = 4'h0;
            else if (r[`DIV_VAL_MSB:0] > 4'h8)
                ratio_of = {1'b0, r[2:0]};
            else
                ratio_of = r[`DIV_VAL_MSB:0];
        end
    endfunction

    // ======================================================================
    // Power sequencing: one-hot states
    localparam [4:0] ST_OFF      = 5'b00001;
    localparam [4:0] ST_WAKE     = 5'b00010;
    localparam [4:0] ST_ACQUIRE  = 5'b00100;
    localparam [4:0] ST_STEADY   = 5'b01000;
    localparam [4:0] ST_SHUTDOWN = 5'b10000;

    reg  [4:0]  state_ff;
    reg  [4:0]  nxt_state;
    reg  [15:0] timer_ff;
    reg  [15:0] nxt_timer;

    // Config-run lets the loaded settings act before done; otherwise wait for done.
    wire run_allowed = done_sync | control_ff[`CTL_CFG_RUN];
    wire power_req   = control_ff[`CTL_ENABLE] & run_allowed;

    always @*
    begin
        nxt_state = state_ff;
        nxt_timer = (timer_ff == 16'h0000) ? 16'h0000 : timer_ff - 16'h0001;
        case (state_ff)
            ST_OFF:
            begin
                if (power_req)
                begin
                    nxt_state = ST_WAKE;
                    nxt_timer = WAKEUP_CYC[15:0];
                end
            end
            ST_WAKE, ST_ACQUIRE, ST_STEADY:
            begin
                if (!power_req)
                begin
                    nxt_state = ST_SHUTDOWN;
                    nxt_timer = SHUTDOWN_CYC[15:0];
                end
                else if (state_ff == ST_WAKE && timer_ff == 16'h0000)
                begin
                    nxt_state = ST_ACQUIRE;
                    nxt_timer = ACQUIRE_CYC[15:0];
                end
                else if (state_ff == ST_ACQUIRE && timer_ff == 16'h0000)
                    nxt_state = ST_STEADY;
            end
            ST_SHUTDOWN:
            begin
                if (timer_ff == 16'h0000)
                    nxt_state = ST_OFF;
            end
            default:
            begin
                nxt_state = ST_OFF;
                nxt_timer = 16'h0000;
            end
        endcase
    end

    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_OFF;
            timer_ff <= 16'h0000;
        end
        else if (gsr_hit)
        begin
            state_ff <= ST_OFF;
            timer_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // ======================================================================
    // Three dividers: the ratio counters run on ref_clk_en.
    wire [23:0] div_regs = {delay_ctrl_ff, feedback_ctrl_ff, prescaler_ctrl_ff};
    wire [2:0]  div_tick;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : div_gen
            reg  [3:0] cnt_ff;
            reg        tick_ff;
            wire [3:0] ratio = ratio_of(div_regs[g*8 +: 8]);
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cnt_ff  <= 4'h0;
                    tick_ff <= 1'b0;
                end
                else if (div_regs[g*8 + `DIV_RST_BIT] || gsr_hit)
                begin
                    // Held in reset the divider sits at its default value, which is bypass.
                    cnt_ff  <= 4'h0;
                    tick_ff <= ref_clk_en;
                end
                else if (ratio == 4'h0)
                begin
                    // Bypass costs one register stage, and so does the divide path.
                    cnt_ff  <= 4'h0;
                    tick_ff <= ref_clk_en;
                end
                else if (ref_clk_en)
                begin
                    cnt_ff  <= (cnt_ff + 4'h1 >= ratio) ? 4'h0 : cnt_ff + 4'h1;
                    tick_ff <= (cnt_ff + 4'h1 >= ratio);
                end
                else
                    tick_ff <= 1'b0;
            end
            assign div_tick[g] = tick_ff;
        end
    endgenerate

    // ======================================================================
    // Registered outputs
    wire powered = (state_ff != ST_OFF);
    // Reads stay released during configuration unless config-run is set, so the
    // data lines never show settings the fabric may not yet own.
    wire read_live = re_sync & run_allowed;

    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data           <= 8'h00;
            rd_data_oe_n      <= 8'hFF;
            analog_power_on   <= 1'b0;
            dll_func_rst      <= 1'b1;
            pll_func_rst      <= 1'b1;
            out_clk_unstable  <= 1'b1;
            lock              <= 1'b0;
            prescaler_en      <= 1'b0;
            feedback_en       <= 1'b0;
            delay_line_en     <= 1'b0;
            prescaler_ratio   <= 4'h0;
            feedback_ratio    <= 4'h0;
            delay_line_ratio  <= 4'h0;
            duty_first_16ths  <= 4'h1;
            duty_second_16ths <= 4'h1;
        end
        else
        begin
            rd_data          <= read_live ? read_mux(addr_s2_ff) : 8'h00;
            rd_data_oe_n     <= {8{~read_live}};
            analog_power_on  <= powered;
            dll_func_rst     <= control_ff[`CTL_DLL_RST] | ~powered;
            pll_func_rst     <= control_ff[`CTL_PLL_RST] | ~powered;
            // A global reset stops the clock, so lock and the stable flag fall together.
            out_clk_unstable <= (state_ff != ST_STEADY) | gsr_hit;
            lock             <= (state_ff == ST_STEADY) & ~gsr_hit;
            prescaler_en     <= div_tick[0] & powered;
            feedback_en      <= div_tick[1] & powered;
            delay_line_en    <= div_tick[2] & powered;
            prescaler_ratio  <= ratio_of(prescaler_ctrl_ff);
            feedback_ratio   <= ratio_of(feedback_ctrl_ff);
            delay_line_ratio <= ratio_of(delay_ctrl_ff);
            // High time in sixteenths of the doubled period.
            duty_first_16ths  <= {duty_ctrl_ff[`DUTY_HI_MASTER], duty_ctrl_ff[2:0]} + 4'h1;
            duty_second_16ths <= {duty_ctrl_ff[`DUTY_LO_MASTER], duty_ctrl_ff[5:3]} + 4'h1;
        end
    end

endmodule

`default_nettype wire

// [rtl/clock_manager_map.vh]
// Register map, field positions, reset values and nanosecond timings of the clock manager control.
// Assumes a single 200 MHz core clock; the fabric port is asynchronous to it.
`ifndef CLOCK_MANAGER_MAP_VH
`define CLOCK_MANAGER_MAP_VH

// ==========================================================================
// Register indices
`define REG_PRESCALER   3'h0
`define REG_FEEDBACK    3'h1
`define REG_DELAY_LINE  3'h2
`define REG_DUTY        3'h3
`define REG_CONTROL     3'h7

// ==========================================================================
// Field positions
`define DIV_VAL_MSB     3
`define DIV_RST_BIT     7
`define CTL_ENABLE      0
`define CTL_PLL_RST     1
`define CTL_DLL_RST     2
`define CTL_CFG_RUN     6
`define CTL_GSR_IMMUNE  7
`define DUTY_HI_MASTER  6
`define DUTY_LO_MASTER  7

// ==========================================================================
// Reset values and masks
`define DIV_RESET       8'h00
`define DUTY_RESET      8'h00
`define CONTROL_RESET   8'h00
`define DIV_WR_MASK     8'h8F
`define CTL_WR_MASK     8'hC7

// ==========================================================================
// Timing, in nanoseconds, and the core clock period
`define CORE_PERIOD_NS  5
`define WAKEUP_NS       1000
`define ACQUIRE_NS      36000
`define SHUTDOWN_NS     1000

`endif

// [bench/fabric_port.sv]
// Fabric-side user logic that drives the clock manager register port.
// Assumes core_clk is the only clock; all its outputs move 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Register port driver and reference tick
module fabric_port (
    input  wire logic       core_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic [7:0] rd_data_oe_n,
    output var  logic [2:0] reg_addr,
    output var  logic [7:0] wr_data,
    output var  logic       read_strobe,
    output var  logic       write_strobe,
    output var  logic       ref_clk_en
);
    initial
    begin
        reg_addr = 3'h0;
        wr_data = 8'h00;
        read_strobe = 1'b0;
        write_strobe = 1'b0;
        ref_clk_en = 1'b0;
    end

    // A tick every other cycle, so gating by the tick is seen.
    always @(posedge core_clk) ref_clk_en <= #1 ~ref_clk_en;

    // Address and data settle three cycles before the strobe; never both strobes.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        begin
            reg_addr = a;
            wr_data = d;
            repeat (3) @(posedge core_clk);
            #1 write_strobe = 1'b1;
            repeat (4) @(posedge core_clk);
            #1 write_strobe = 1'b0;
            repeat (4) @(posedge core_clk);
            #1;
        end
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] oe);
        begin
            reg_addr = a;
            repeat (3) @(posedge core_clk);
            #1 read_strobe = 1'b1;
            repeat (4) @(posedge core_clk);
            #1;
            d = rd_data;
            oe = rd_data_oe_n;
            read_strobe = 1'b0;
            repeat (4) @(posedge core_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// [bench/clock_manager_ctrl_asserts.sv]
// Port checker of the clock manager control block.
// Assumes the single clock core_clk and the active-low asynchronous reset nrst.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Checker
module clock_manager_ctrl_asserts #(
    parameter WAKEUP_CYC   = 200,
    parameter ACQUIRE_CYC  = 7200,
    parameter SHUTDOWN_CYC = 200
) (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       read_strobe,
    input wire logic       ref_clk_en,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] rd_data_oe_n,
    input wire logic       analog_power_on,
    input wire logic       dll_func_rst,
    input wire logic       pll_func_rst,
    input wire logic       out_clk_unstable,
    input wire logic       lock,
    input wire logic       prescaler_en,
    input wire logic [3:0] prescaler_ratio,
    input wire logic [3:0] feedback_ratio,
    input wire logic [3:0] delay_line_ratio
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_release; !read_strobe [*5] |-> rd_data_oe_n == 8'hFF; endproperty
    a_release: assert property (p_release)
        else $error("read port not released");
    property p_idle_zero; rd_data_oe_n == 8'hFF |-> rd_data == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not zero while released");
    property p_lock_stable; lock |-> !out_clk_unstable; endproperty
    a_lock_stable: assert property (p_lock_stable)
        else $error("lock while unstable");
    property p_lock_power; lock |-> analog_power_on; endproperty
    a_lock_power: assert property (p_lock_power)
        else $error("lock without supply");
    property p_off_rst; !analog_power_on |-> dll_func_rst && pll_func_rst; endproperty
    a_off_rst: assert property (p_off_rst)
        else $error("function logic live while off");
    property p_lock_fall; $fell(lock) |-> out_clk_unstable; endproperty
    a_lock_fall: assert property (p_lock_fall)
        else $error("lock lost without unstable flag");
    property p_wake; $rose(analog_power_on) |-> !lock [*8]; endproperty
    a_wake: assert property (p_wake)
        else $error("lock during wake-up");
    property p_range;
        prescaler_ratio <= 4'h8 && feedback_ratio <= 4'h8 && delay_line_ratio <= 4'h8;
    endproperty
    a_range: assert property (p_range)
        else $error("ratio above eight");
    property p_bypass;
        $past(prescaler_ratio) == 4'h0 && analog_power_on
            |-> prescaler_en == $past(ref_clk_en, 2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass tick not passed");
endmodule

bind clock_manager_ctrl clock_manager_ctrl_asserts #(
    .WAKEUP_CYC(WAKEUP_CYC), .ACQUIRE_CYC(ACQUIRE_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC)
) i_clock_manager_ctrl_asserts (.core_clk, .nrst, .read_strobe, .ref_clk_en, .rd_data,
    .rd_data_oe_n, .analog_power_on, .dll_func_rst, .pll_func_rst, .out_clk_unstable,
    .lock, .prescaler_en, .prescaler_ratio, .feedback_ratio, .delay_line_ratio);
`default_nettype wire

// [bench/tb_clock_manager_ctrl.sv]
// Self-checking bench of the clock manager control block.
// Assumes fabric_port as the fabric side; counts are shortened by parameters.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bench
module tb_clock_manager_ctrl;
    logic core_clk = 1'b0, nrst = 1'b0, config_done = 1'b0, global_set_reset_n = 1'b1;
    logic [2:0] reg_addr;
    logic [7:0] wr_data, rd_data, rd_data_oe_n, d, oe, v;
    logic read_strobe, write_strobe, ref_clk_en, analog_power_on, dll_func_rst;
    logic pll_func_rst, out_clk_unstable, lock, prescaler_en, feedback_en, delay_line_en;
    logic [3:0] prescaler_ratio, feedback_ratio, delay_line_ratio, duty_first_16ths;
    logic [3:0] duty_second_16ths;
    int n_mismatch = 0, num_checks = 0, i, r, cnt, c2;
    logic [7:0] duty_tab [5] = '{8'hC9, 8'h00, 8'hFF, 8'h47, 8'h98};

    always #2.5 core_clk = ~core_clk;

    clock_manager_ctrl #(.WAKEUP_CYC(4), .ACQUIRE_CYC(8), .SHUTDOWN_CYC(4))
    i_clock_manager_ctrl (.core_clk, .nrst, .reg_addr, .wr_data, .read_strobe,
        .write_strobe, .config_done, .global_set_reset_n, .ref_clk_en, .rd_data,
        .rd_data_oe_n, .analog_power_on, .dll_func_rst, .pll_func_rst, .out_clk_unstable,
        .lock, .prescaler_en, .feedback_en, .delay_line_en, .prescaler_ratio,
        .feedback_ratio, .delay_line_ratio, .duty_first_16ths, .duty_second_16ths);

    fabric_port i_fabric_port (.core_clk, .rd_data, .rd_data_oe_n, .reg_addr, .wr_data,
        .read_strobe, .write_strobe, .ref_clk_en);

    task automatic report_and_stop;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            num_checks++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Bounded wait; running out of the bound ends the run at once.
    task automatic waitv(ref logic s, input logic val);
        begin
            for (i = 0; i < 200 && s !== val; i++)
            begin
                @(posedge core_clk);
                #1;
            end
            chk({7'h00, s}, {7'h00, val});
            if (s !== val) report_and_stop;
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] dat);
        i_fabric_port.wr(a, dat);
    endtask

    task automatic rd(input logic [2:0] a);
        i_fabric_port.rd(a, d, oe);
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 rd(3'h0);
        chk(oe, 8'hFF);
        chk({7'h00, analog_power_on}, 8'h00);
        wr(3'h7, 8'h01);
        chk({7'h00, analog_power_on}, 8'h00);
        rd(3'h7);
        chk(d, 8'h00);
        chk(oe, 8'hFF);
        wr(3'h7, 8'h41);
        waitv(analog_power_on, 1'b1);
        wr(3'h7, 8'h40);
        waitv(analog_power_on, 1'b0);
        $display("test configuration done");
        config_done = 1'b1;
        for (r = 0; r < 4; r++)
        begin
            rd(r[2:0]);
            chk(d, 8'h00);
            chk(oe, 8'h00);
        end
        rd(3'h5);
        chk(d, 8'h00);
        wr(3'h0, 8'hF9);
        rd(3'h0);
        chk(d, 8'h89);
        chk({4'h0, prescaler_ratio}, 8'h00);
        wr(3'h0, 8'h79);
        chk({4'h0, prescaler_ratio}, 8'h01);
        wr(3'h2, 8'h8C);
        chk({4'h0, delay_line_ratio}, 8'h00);
        wr(3'h2, 8'h0C);
        chk({4'h0, delay_line_ratio}, 8'h04);
        $display("test divider resets done");
        wr(3'h7, 8'h01);
        waitv(analog_power_on, 1'b1);
        for (v = 8'h00; v < 8'h10; v++)
        begin
            wr(3'h1, v);
            r = (v > 8) ? v % 8 : v;
            chk({4'h0, feedback_ratio}, r[7:0]);
            cnt = 0;
            c2 = 0;
            repeat (1680)
            begin
                @(posedge core_clk);
                cnt += (feedback_en === 1'b1);
                c2 += (delay_line_en === 1'b1);
            end
            chk(cnt[7:0], ((r == 0) ? 840 : 840 / r) % 256);
            chk(c2[7:0], 8'hD2);
            #1;
        end
        wr(3'h1, 8'h83);
        chk({4'h0, feedback_ratio}, 8'h00);
        $display("test ratios done");
        foreach (duty_tab[r])
        begin
            wr(3'h3, duty_tab[r]);
            v = duty_tab[r];
            chk({4'h0, duty_first_16ths}, {4'h0, 4'(v[6] * 8 + v[2:0] + 1)});
            chk({4'h0, duty_second_16ths}, {4'h0, 4'(v[7] * 8 + v[5:3] + 1)});
        end
        $display("test duty done");
        wr(3'h0, 8'h03);
        wr(3'h7, 8'h01);
        waitv(lock, 1'b1);
        wr(3'h7, 8'h07);
        chk({6'h00, dll_func_rst, pll_func_rst}, 8'h03);
        rd(3'h0);
        chk(d, 8'h03);
        wr(3'h7, 8'h81);
        waitv(lock, 1'b1);
        global_set_reset_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 global_set_reset_n = 1'b1;
        chk({7'h00, lock}, 8'h01);
        rd(3'h0);
        chk(d, 8'h03);
        wr(3'h7, 8'h01);
        global_set_reset_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 global_set_reset_n = 1'b1;
        rd(3'h0);
        chk(d, 8'h00);
        rd(3'h7);
        chk(d, 8'h01);
        waitv(lock, 1'b1);
        wr(3'h7, 8'h00);
        waitv(analog_power_on, 1'b0);
        chk({7'h00, lock}, 8'h00);
        $display("test power done");
        report_and_stop;
    end
endmodule
`default_nettype wire
